// File: hdl/hps_pkg.sv
`default_nettype none
package hps_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] REG_SLOT_OFS = 12'h0f8;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ****************************************
  // Slot control field positions
  // ****************************************
  localparam int CTL_ABP_EN   = 0;
  localparam int CTL_PFD_EN   = 1;
  localparam int CTL_PDC_EN   = 3;
  localparam int CTL_CC_EN    = 4;
  localparam int CTL_HPI_EN   = 5;
  localparam int CTL_ATN_LSB  = 6;
  localparam int CTL_PIND_LSB = 8;
  localparam int CTL_PWR_OFF  = 10;
  localparam int CTL_DLL_EN   = 12;

  localparam logic [15:0] CTL_WMASK = 16'h17fb;
  localparam logic [15:0] CTL_RESET = 16'h03c0;

  // ****************************************
  // Slot status field positions
  // ****************************************
  localparam int STS_ABP   = 16;
  localparam int STS_PFD   = 17;
  localparam int STS_MRLC  = 18;
  localparam int STS_PDC   = 19;
  localparam int STS_CC    = 20;
  localparam int STS_MRL   = 21;
  localparam int STS_PRES  = 22;
  localparam int STS_DLLSC = 24;

  localparam logic STS_MRL_RESET  = 1'b0;
  localparam logic STS_PRES_RESET = 1'b1;

  // ****************************************
  // Indicator coding
  // ****************************************
  localparam logic [1:0] IND_RSVD  = 2'h0;
  localparam logic [1:0] IND_ON    = 2'h1;
  localparam logic [1:0] IND_BLINK = 2'h2;
  localparam logic [1:0] IND_OFF   = 2'h3;

  // ****************************************
  // Command completion timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int CMD_TIME_NS   = 40;
  localparam int CMD_CYCLES    = (CMD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CMD_CNT_W     = 4;

  typedef enum logic {
    CMD_IDLE,
    CMD_BUSY
  } hps_cmd_t;

endpackage
`default_nettype wire

// File: hdl/hps_pin_sync.sv
`default_nettype none
module hps_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic din,
  output var  logic level,
  output var  logic rise,
  output var  logic chg
);

  logic meta;
  logic sync;
  logic prev;

  // ****************************************
  // Two-stage synchroniser
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta <= RST_VAL;
      sync <= RST_VAL;
      prev <= RST_VAL;
    end else begin
      meta <= din;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level = sync;
  assign rise  = sync & ~prev;
  assign chg   = sync ^ prev;

endmodule
`default_nettype wire

// File: hdl/hps_slot_regs.sv
// What this block does
// RULE1: Button enable gates button event
// RULE2: Power fault enable gates fault event
// RULE3: Presence change enable gates presence event
// RULE4: Command completed enable gates completion interrupt
// RULE5: Master enable gates every interrupt
// RULE6: Attention indicator field, resets to off
// RULE7: Attention field write sends indicator message
// RULE8: Power indicator field, resets to off
// RULE9: Power field write sends indicator message
// RULE10: Power control bit, one means off
// RULE11: Link state change enable gates notification
// RULE12: Button pressed flag, write one clears
// RULE13: Power fault flag, write one clears
// RULE14: Latch sensor change flag, read only
// RULE15: Presence changed flag, write one clears
// RULE16: Command completed flag, write one clears
// RULE17: Live latch sensor state, open is one
// RULE18: Live card presence, resets to one
// RULE19: No slot implemented reads presence one
// RULE20: Link active change flag, write one clears
// RULE21: Set wins over write-one clear
// RULE22: Interrupt when master and enabled flag
//
// Register access over AXI4-Lite was left to the implementer.
`default_nettype none
module hps_slot_regs
  import hps_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              attn_button,
  input  wire logic              power_fault,
  input  wire logic              mrl_open,
  input  wire logic              card_present,
  input  wire logic              slot_implemented,
  input  wire logic              link_active,
  output var  logic              atn_msg_valid,
  output var  logic [1:0]        atn_msg_code,
  output var  logic              pind_msg_valid,
  output var  logic [1:0]        pind_msg_code,
  output var  logic              slot_pwr_off,
  output var  logic              hp_irq,
  output var  logic              hp_wake
);

  localparam int CC_LAT = CMD_CYCLES + 1;
  // ****************************************
  // Declarations
  // ****************************************
  logic [ADDR_W-1:0]    aw_addr;
  logic [31:0]          w_data, reg_word;
  logic [15:0]          ctl, ctl_lane, sts_clr;
  logic [3:0]           w_strb;
  logic [CMD_CNT_W-1:0] cmd_cnt;
  hps_cmd_t             cmd_state;
  logic                 aw_held, w_held, do_write, wr_hit, rd_hit;
  logic                 sts_abp, sts_pfd, sts_mrlc, sts_pdc, sts_cc, sts_dllsc;
  logic                 link_prev, link_chg, btn_rise, pf_rise, cmd_done, ev_irq, ev_wake;
  logic                 mrl_lvl, mrl_chg, pres_lvl, pres_chg, slot_impl, pres_rd;

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = ({a[ADDR_W-1:2], 2'h0} == ADDR_W'(REG_SLOT_OFS));
  endfunction
  function automatic logic w1c(input logic cur, input logic set, input logic clr);
    w1c = set | (cur & ~clr);
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  hps_pin_sync #(.RST_VAL(1'b0)) u_sync_btn (
    .clock(clock), .nrst(nrst), .din(attn_button), .level(), .rise(btn_rise), .chg()
  );
  hps_pin_sync #(.RST_VAL(1'b0)) u_sync_pf (
    .clock(clock), .nrst(nrst), .din(power_fault), .level(), .rise(pf_rise), .chg()
  );
  hps_pin_sync #(.RST_VAL(STS_MRL_RESET)) u_sync_mrl (
    .clock(clock), .nrst(nrst), .din(mrl_open), .level(mrl_lvl), .rise(), .chg(mrl_chg)
  );
  // RULE18: presence resets one
  hps_pin_sync #(.RST_VAL(STS_PRES_RESET)) u_sync_pres (
    .clock(clock), .nrst(nrst), .din(card_present), .level(pres_lvl), .rise(), .chg(pres_chg)
  );
  hps_pin_sync #(.RST_VAL(1'b1)) u_sync_slot (
    .clock(clock), .nrst(nrst), .din(slot_implemented), .level(slot_impl), .rise(), .chg()
  );

  // ****************************************
  // AXI write channel
  // ****************************************
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign do_write      = aw_held & w_held & ~s_axi_bvalid;
  assign wr_hit        = do_write & hit(aw_addr);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aw_addr <= '0;
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr <= s_axi_awaddr;
      aw_held <= 1'b1;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      w_data <= '0;
      w_strb <= '0;
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      w_held <= 1'b1;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // AXI read channel
  // ****************************************
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_hit        = hit(s_axi_araddr);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? reg_word : 32'h0000_0000;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // RULE19: presence forced when no slot
  assign pres_rd = pres_lvl | ~slot_impl;

  // RULE17: live latch state readback
  always_comb begin
    reg_word             = '0;
    reg_word[15:0]       = ctl;
    reg_word[STS_ABP]    = sts_abp;
    reg_word[STS_PFD]    = sts_pfd;
    reg_word[STS_MRLC]   = sts_mrlc;
    reg_word[STS_PDC]    = sts_pdc;
    reg_word[STS_CC]     = sts_cc;
    reg_word[STS_MRL]    = mrl_lvl;
    reg_word[STS_PRES]   = pres_rd;
    reg_word[STS_DLLSC]  = sts_dllsc;
  end

  // ****************************************
  // Slot control register
  // ****************************************
  assign ctl_lane = {{8{w_strb[1]}}, {8{w_strb[0]}}} & CTL_WMASK;

  // RULE6: indicators reset to off
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctl <= CTL_RESET;
    end else if (wr_hit) begin
      ctl <= (ctl & ~ctl_lane) | (w_data[15:0] & ctl_lane);
    end
  end

  // RULE10: slot power from control bit
  assign slot_pwr_off = ctl[CTL_PWR_OFF];

  // ****************************************
  // Indicator messages
  // ****************************************
  // RULE7: attention message on write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      atn_msg_valid <= 1'b0;
      atn_msg_code  <= IND_OFF;
    end else begin
      atn_msg_valid <= wr_hit & w_strb[0];
      if (wr_hit && w_strb[0]) begin
        atn_msg_code <= w_data[CTL_ATN_LSB +: 2];
      end
    end
  end

  // RULE8: power indicator coding shared
  // RULE9: power message on write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pind_msg_valid <= 1'b0;
      pind_msg_code  <= IND_OFF;
    end else begin
      pind_msg_valid <= wr_hit & w_strb[1];
      if (wr_hit && w_strb[1]) begin
        pind_msg_code <= w_data[CTL_PIND_LSB +: 2];
      end
    end
  end

  // ****************************************
  // Command completion
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmd_state <= CMD_IDLE;
      cmd_cnt   <= '0;
    end else if (wr_hit && (w_strb[1:0] != 2'h0)) begin
      cmd_state <= CMD_BUSY;
      cmd_cnt   <= CMD_CNT_W'(CMD_CYCLES - 1);
    end else begin
      case (cmd_state)
        CMD_BUSY: begin
          if (cmd_cnt == '0) begin
            cmd_state <= CMD_IDLE;
          end else begin
            cmd_cnt <= cmd_cnt - 1'b1;
          end
        end
        default: begin
          cmd_state <= CMD_IDLE;
          cmd_cnt   <= '0;
        end
      endcase
    end
  end

  assign cmd_done = (cmd_state == CMD_BUSY) && (cmd_cnt == '0);

  // ****************************************
  // Slot status flags
  // ****************************************
  assign sts_clr  = w_data[31:16] & {{8{w_strb[3]}}, {8{w_strb[2]}}} & {16{wr_hit}};
  assign link_chg = link_active ^ link_prev;

  // RULE21: set beats clear
  // RULE12: button flag
  // RULE13: fault flag
  // RULE15: presence change flag
  // RULE16: completion flag
  // RULE20: link change flag
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sts_abp   <= 1'b0;
      sts_pfd   <= 1'b0;
      sts_pdc   <= 1'b0;
      sts_cc    <= 1'b0;
      sts_dllsc <= 1'b0;
      link_prev <= 1'b0;
    end else begin
      sts_abp   <= w1c(sts_abp, btn_rise, sts_clr[STS_ABP-16]);
      sts_pfd   <= w1c(sts_pfd, pf_rise, sts_clr[STS_PFD-16]);
      sts_pdc   <= w1c(sts_pdc, pres_chg, sts_clr[STS_PDC-16]);
      sts_cc    <= w1c(sts_cc, cmd_done, sts_clr[STS_CC-16]);
      sts_dllsc <= w1c(sts_dllsc, link_chg, sts_clr[STS_DLLSC-16]);
      link_prev <= link_active;
    end
  end

  // RULE14: latch change, reset only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sts_mrlc <= 1'b0;
    end else if (mrl_chg) begin
      sts_mrlc <= 1'b1;
    end
  end

  // ****************************************
  // Interrupt and wakeup
  // ****************************************
  // RULE1: button enable
  // RULE2: fault enable
  // RULE3: presence enable
  // RULE11: link change enable
  assign ev_wake = (sts_abp & ctl[CTL_ABP_EN]) | (sts_pfd & ctl[CTL_PFD_EN]) |
                   (sts_pdc & ctl[CTL_PDC_EN]) | (sts_dllsc & ctl[CTL_DLL_EN]);
  // RULE4: completion enable
  assign ev_irq  = ev_wake | (sts_cc & ctl[CTL_CC_EN]);

  // RULE5: master gate
  // RULE22: combined interrupt
  assign hp_irq  = ctl[CTL_HPI_EN] & ev_irq;
  assign hp_wake = ~ctl[CTL_HPI_EN] & ev_wake;

  // ****************************************
  // Assertions
  // ****************************************
  AST_IRQ_MASTER: assert property (@(posedge clock) disable iff (!nrst) // RULE5
    !ctl[CTL_HPI_EN] |-> !hp_irq)
    else $error("interrupt without master enable");
  AST_IRQ_BUTTON: assert property (@(posedge clock) disable iff (!nrst) // RULE1
    (ctl[CTL_HPI_EN] && ctl[CTL_ABP_EN] && sts_abp) |-> hp_irq)
    else $error("enabled button event gave no interrupt");
  AST_IRQ_CMD: assert property (@(posedge clock) disable iff (!nrst) // RULE4
    (ctl[CTL_HPI_EN] && !ctl[CTL_CC_EN] && !ev_wake) |-> !hp_irq)
    else $error("disabled completion raised interrupt");
  AST_PFD_SET: assert property (@(posedge clock) disable iff (!nrst) // RULE13
    pf_rise |=> sts_pfd)
    else $error("power fault not flagged");
  AST_SET_WINS: assert property (@(posedge clock) disable iff (!nrst) // RULE21
    (pres_chg && sts_clr[STS_PDC-16]) |=> sts_pdc)
    else $error("clear won over presence event");
  AST_W1C_CLEARS: assert property (@(posedge clock) disable iff (!nrst) // RULE12
    (sts_clr[STS_ABP-16] && !btn_rise) |=> !sts_abp)
    else $error("button flag not cleared");
  AST_ATN_MSG: assert property (@(posedge clock) disable iff (!nrst) // RULE7
    (wr_hit && w_strb[0]) |=> (atn_msg_valid && atn_msg_code == $past(w_data[7:6])))
    else $error("attention message missing");
  AST_PIND_MSG: assert property (@(posedge clock) disable iff (!nrst) // RULE9
    (wr_hit && w_strb[1]) |=> (pind_msg_valid && pind_msg_code == $past(w_data[9:8])))
    else $error("power indicator message missing");
  AST_PRES_NOSLOT: assert property (@(posedge clock) disable iff (!nrst) // RULE19
    !slot_impl |-> reg_word[STS_PRES])
    else $error("presence not forced high");
  AST_CMD_DONE: assert property (@(posedge clock) disable iff (!nrst) // RULE16
    (wr_hit && w_strb[1:0] != 2'h0) |-> ##[1:CC_LAT] sts_cc)
    else $error("command completion not flagged");
  AST_DLL_CHG: assert property (@(posedge clock) disable iff (!nrst) // RULE20
    (link_active != $past(link_active)) |=> sts_dllsc)
    else $error("link change not flagged");
  AST_MRLC_HOLD: assert property (@(posedge clock) disable iff (!nrst) // RULE14
    sts_mrlc |=> sts_mrlc)
    else $error("latch change flag dropped");
  AST_PWR_CTL: assert property (@(posedge clock) disable iff (!nrst) // RULE10
    (wr_hit && w_strb[1]) |=> slot_pwr_off == $past(w_data[CTL_PWR_OFF]))
    else $error("power control not updated");
  COV_IRQ: cover property (@(posedge clock) disable iff (!nrst) $rose(hp_irq));
  COV_CMD: cover property (@(posedge clock) disable iff (!nrst) $rose(sts_cc));
  COV_SET_CLR: cover property (@(posedge clock) disable iff (!nrst) pres_chg && sts_clr[STS_PDC-16]);
  COV_UNMAPPED: cover property (@(posedge clock) disable iff (!nrst) do_write && !wr_hit);

endmodule
`default_nettype wire

// File: verif/hps_slot_model.sv
`default_nettype none
module hps_slot_model (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [5:0]  want,
  input  wire logic        atn_msg_valid,
  input  wire logic        pind_msg_valid,
  output var  logic [5:0]  pins,
  output var  logic [31:0] atn_cnt,
  output var  logic [31:0] pind_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Slot pins, moved only at clock edges
  // ****************************************
  always_ff @(posedge clock) begin
    pins <= want;
  end

  // ****************************************
  // Indicator message receiver
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      atn_cnt  <= '0;
      pind_cnt <= '0;
    end else begin
      atn_cnt  <= atn_cnt + {31'h0, atn_msg_valid};
      pind_cnt <= pind_cnt + {31'h0, pind_msg_valid};
    end
  end
endmodule
`default_nettype wire

// File: verif/tb_pcie_slot_hotplug_ctrl_status.sv
`default_nettype none
module tb_pcie_slot_hotplug_ctrl_status
  import hps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals
  // ****************************************
  logic             clock;
  logic             nrst;
  logic [11:0]      awaddr;
  logic [11:0]      araddr;
  logic             awvalid;
  logic             wvalid;
  logic             bready;
  logic             arvalid;
  logic             rready;
  logic [31:0]      wdata;
  logic [3:0]       wstrb;
  logic [5:0]       want;
  logic [15:0]      ctl;
  logic [15:0]      sts;
  logic [31:0]      d;
  logic [1:0]       r;
  wire logic        awready, wready, bvalid, arready, rvalid;
  wire logic        atn_v, pind_v, pwr_off, irq, wake;
  wire logic [1:0]  bresp, rresp, atn_code, pind_code;
  wire logic [31:0] rdata, atn_cnt, pind_cnt;
  wire logic [5:0]  pins;
  int               na, np, errors, comparisons, seed, i;

  hps_slot_regs u_dut (
    .clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .attn_button(pins[0]), .power_fault(pins[1]),
    .mrl_open(pins[2]), .card_present(pins[3]), .slot_implemented(pins[4]), .link_active(pins[5]),
    .atn_msg_valid(atn_v), .atn_msg_code(atn_code), .pind_msg_valid(pind_v), .pind_msg_code(pind_code),
    .slot_pwr_off(pwr_off), .hp_irq(irq), .hp_wake(wake)
  );

  hps_slot_model u_slot (
    .clock(clock), .nrst(nrst), .want(want), .atn_msg_valid(atn_v), .pind_msg_valid(pind_v),
    .pins(pins), .atn_cnt(atn_cnt), .pind_cnt(pind_cnt)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ****************************************
  // Checking and expectations
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [1:0] exp_int(input logic [15:0] c, input logic [15:0] s);
    logic [4:0] ev;
    ev = {c[12] & s[8], c[4] & s[4], c[3] & s[3], c[1] & s[1], c[0] & s[0]};
    return {c[5] & (|ev), !c[5] & (|(ev & 5'h17))};
  endfunction

  // ****************************************
  // AXI4-Lite master
  // ****************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s, output logic [1:0] rr);
    logic pa;
    logic pw;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= dd;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(posedge clock);
      if (pa && awready === 1'b1) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] dd, output logic [1:0] rr);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    dd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk_all;
    logic [1:0] e;
    rd(REG_SLOT_OFS, d, r);
    e = exp_int(ctl, sts);
    chk("slot word", {sts | {9'h0, !want[4] | want[3], want[2], 5'h0}, ctl}, d);
    chk("rresp", RESP_OKAY, r);
    chk("hp_irq", e[1], irq);
    chk("hp_wake", e[0], wake);
    chk("slot_pwr_off", ctl[10], pwr_off);
    chk("atn msgs", na, atn_cnt);
    chk("pind msgs", np, pind_cnt);
  endtask

  task automatic wr_slot(input logic [31:0] dd, input logic [3:0] s);
    wr(REG_SLOT_OFS, dd, s, r);
    chk("bresp", RESP_OKAY, r);
    ctl = (ctl & ~({{8{s[1]}}, {8{s[0]}}} & CTL_WMASK)) | (dd[15:0] & {{8{s[1]}}, {8{s[0]}}} & CTL_WMASK);
    // Clear applied first, a command lane then completes a new command
    sts = sts & ~(dd[31:16] & {{8{s[3]}}, {8{s[2]}}} & 16'h011b);
    if (s[1:0] != 2'b00)
      sts[4] = 1'b1;
    na += int'(s[0]);
    np += int'(s[1]);
    repeat (12) @(posedge clock);
    if (s[0])
      chk("atn code", dd[7:6], atn_code);
    if (s[1])
      chk("pind code", dd[9:8], pind_code);
    chk_all;
  endtask

  task automatic ev(input int idx, input logic v);
    if (idx < 2 && v && !want[idx])
      sts[idx] = 1'b1;
    if ((idx == 2 || idx == 3) && v != want[idx])
      sts[idx] = 1'b1;
    if (idx == 5 && v != want[5])
      sts[8] = 1'b1;
    want[idx] <= v;
    repeat (8) @(posedge clock);
    chk_all;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    seed = 32'h71f1;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    want = 6'h18;
    {errors, comparisons, na, np} = '0;
    nrst = 1'b0;
    ctl = CTL_RESET;
    sts = 16'h0000;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (8) @(posedge clock);
    chk("atn code", IND_OFF, atn_code);
    chk("pind code", IND_OFF, pind_code);
    chk_all;
    for (i = 0; i < 4; i++)
      wr_slot({22'h0, i[1:0], i[1:0], 6'h0}, 4'h3);
    for (i = 0; i < 12; i++)
      wr_slot($random(seed), 4'($random(seed)));
    wr_slot(32'h0000_17fb, 4'h3);
    wr_slot(32'h0010_0000, 4'h4);
    foreach (want[k])
      if (k != 4)
        ev(k, 1'b1);
    ev(0, 1'b0);
    ev(1, 1'b0);
    wr_slot(32'hffff_0000, 4'hc);
    wr_slot(32'h0000_13db, 4'h3);
    ev(0, 1'b1);
    ev(5, 1'b0);
    ev(3, 1'b0);
    ev(4, 1'b0);
    ev(4, 1'b1);
    // Presence edge lands on the clear of its own flag
    want[3] <= 1'b1;
    @(posedge clock);
    wr(REG_SLOT_OFS, 32'h0008_0000, 4'h4, r);
    chk("bresp", RESP_OKAY, r);
    repeat (8) @(posedge clock);
    chk_all;
    wr(12'h0f4, 32'hffff_ffff, 4'hf, r);
    chk("bresp unmapped", RESP_SLVERR, r);
    rd(12'h100, d, r);
    chk("rdata unmapped", 32'h0000_0000, d);
    chk("rresp unmapped", RESP_SLVERR, r);
    chk_all;
    test_done;
  end

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    test_done;
  end
endmodule
`default_nettype wire
